// File: brightness_failsafe_regs.sv
// Operation
// - Bit 7 of brightness_control picks the exponential curve when 1, linear when 0.
// - Bit 6 of brightness_control turns phase-shifted PWM on when 1, off when 0.
// - Bit 5 of brightness_control turns 12-bit PWM resolution on when 1.
// - Bit 4 of brightness_control turns digital power-save mode on when 1.
// - Bits 3:0 pick the PWM rate, codes 0 to F giving 200 up to 20800 Hz.
// - After reset, every configurable field is loaded from nonvolatile memory.
// - The spare register at 7Fh always reads zero and resets to 00h.
// - In fail-safe, each group A output follows the input its bit (2:0) selects.
// - In fail-safe, group B outputs 2..0 follow the input chosen by bits 6..4.
`timescale 1ns/100ps
`include "led_regs_cfg.svh"

module brightness_failsafe_regs
    import led_cfg_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Nonvolatile image, valid from reset release
    input wire logic [7:0] nvm_brightness,
    input wire logic [7:0] nvm_fs_select,
    // Fail-safe control
    input wire logic failsafe_active,
    input wire logic failsafe_input_zero,
    input wire logic failsafe_input_one,
    input wire logic [2:0] normal_a,
    input wire logic [2:0] normal_b,
    // Brightness settings
    output logic exponential_curve_enable,
    output logic phase_shift_enable,
    output logic fine_resolution_enable,
    output logic power_save_enable,
    output logic [3:0] pulse_rate_select,
    output logic [14:0] pulse_rate_hz,
    // Channel outputs
    output logic group_a_output_0,
    output logic group_a_output_1,
    output logic group_a_output_2,
    output logic group_b_output_0,
    output logic group_b_output_1,
    output logic group_b_output_2
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    load_state_t st_q, st_d;
    logic [7:0] bright_q, bright_d;
    logic [7:0] fssel_q, fssel_d;
    logic wr_bright_q, wr_bright_d;
    logic wr_fs_q, wr_fs_d;
    logic [31:0] rdata_q, rdata_d;
    logic [14:0] rate_q, rate_d;
    logic ready_q;
    logic resp_q;
    logic addr_phase;
    logic [7:0] rd_byte;
    logic [1:0] fs_level;

    assign addr_phase = hsel && htrans[`TRANS_ACTIVE_BIT] && hready;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        st_d = ST_RUN;
        bright_d = bright_q;
        fssel_d = fssel_q;
        wr_bright_d = addr_phase && hwrite && reg_sel(haddr, `BRC_IDX);
        wr_fs_d = addr_phase && hwrite && reg_sel(haddr, `FSSEL0_IDX);
        unique case (st_q)
            ST_LOAD: begin
                // Configuration comes from the nonvolatile image
                bright_d = nvm_brightness;
                fssel_d = nvm_fs_select & `FSSEL_WMASK;
            end
            ST_RUN: begin
                if (wr_bright_q) begin
                    bright_d = hwdata[7:0];
                end
                if (wr_fs_q) begin
                    fssel_d = hwdata[7:0] & `FSSEL_WMASK;
                end
            end
        endcase

        // Read data is taken from the next values, so a read that
        // follows a write directly sees the new contents.
        rd_byte = `REG_RST;
        if (reg_sel(haddr, `BRC_IDX)) begin
            rd_byte = bright_d;
        end else if (reg_sel(haddr, `SPARE_IDX)) begin
            rd_byte = `SPARE_VALUE;
        end else if (reg_sel(haddr, `FSSEL0_IDX)) begin
            rd_byte = fssel_d;
        end
        rdata_d = rdata_q;
        if (addr_phase && !hwrite) begin
            rdata_d = {24'h00_0000, rd_byte};
        end

        rate_d = rate_hz(bright_d[`RATE_MSB:`RATE_LSB]);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_q <= ST_LOAD;
            bright_q <= `REG_RST;
            fssel_q <= `REG_RST;
            wr_bright_q <= 1'b0;
            wr_fs_q <= 1'b0;
            rdata_q <= `WORD_ZERO;
            rate_q <= `RATE_RST;
            ready_q <= 1'b1;
            resp_q <= 1'b0;
        end else begin
            st_q <= st_d;
            bright_q <= bright_d;
            fssel_q <= fssel_d;
            wr_bright_q <= wr_bright_d;
            wr_fs_q <= wr_fs_d;
            rdata_q <= rdata_d;
            rate_q <= rate_d;
            // Zero wait states and always OKAY
            ready_q <= 1'b1;
            resp_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Fail-safe path
    // ------------------------------------------------------------
    fs_map_if fm ();

    // Fail-safe inputs are pins and need filtering first
    fs_pin_sync u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin({failsafe_input_one, failsafe_input_zero}),
        .level(fs_level)
    );

    assign fm.sel_a = fssel_q[`A_SEL_MSB:`A_SEL_LSB];
    assign fm.sel_b = fssel_q[`B_SEL_MSB:`B_SEL_LSB];
    assign fm.level = fs_level;
    assign fm.active = failsafe_active;
    assign fm.normal_a = normal_a;
    assign fm.normal_b = normal_b;

    fs_output_mux u_mux (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .fm(fm)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hrdata = rdata_q;
    assign hreadyout = ready_q;
    assign hresp = resp_q;
    assign exponential_curve_enable = bright_q[`EXP_BIT];
    assign phase_shift_enable = bright_q[`PHASE_BIT];
    assign fine_resolution_enable = bright_q[`FINE_BIT];
    assign power_save_enable = bright_q[`SAVE_BIT];
    assign pulse_rate_select = bright_q[`RATE_MSB:`RATE_LSB];
    assign pulse_rate_hz = rate_q;
    assign group_a_output_0 = fm.out_a[0];
    assign group_a_output_1 = fm.out_a[1];
    assign group_a_output_2 = fm.out_a[2];
    assign group_b_output_0 = fm.out_b[0];
    assign group_b_output_1 = fm.out_b[1];
    assign group_b_output_2 = fm.out_b[2];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // Sampled reset keeps the release edge itself out of the check
    sequence s_load;
        rst_n && st_q == ST_LOAD;
    endsequence

    sequence s_bright_write;
        wr_bright_q && st_q == ST_RUN;
    endsequence

    sequence s_fs_write;
        wr_fs_q && st_q == ST_RUN;
    endsequence

    property p_curve_bit;
        s_bright_write |=>
            exponential_curve_enable == $past(hwdata[7]);
    endproperty
    a_curve_bit: assert property (p_curve_bit)
        else $error("curve select did not follow write");

    property p_phase_bit;
        s_bright_write ##1 !wr_bright_q |->
            phase_shift_enable == $past(hwdata[`PHASE_BIT]);
    endproperty
    a_phase_bit: assert property (p_phase_bit)
        else $error("phase shift enable lost or wrong");

    property p_fine_bit;
        s_bright_write |=> fine_resolution_enable == $past(hwdata[5]);
    endproperty
    a_fine_bit: assert property (p_fine_bit)
        else $error("fine resolution enable wrong");

    property p_save_bit;
        !wr_bright_q && st_q == ST_RUN |=> $stable(power_save_enable);
    endproperty
    a_save_bit: assert property (p_save_bit)
        else $error("power save changed without a write");

    property p_rate;
        (s_bright_write |=> pulse_rate_select == $past(hwdata[3:0]))
        and (pulse_rate_hz == rate_hz(pulse_rate_select));
    endproperty
    a_rate: assert property (p_rate)
        else $error("pulse rate code or frequency wrong");

    property p_nvm_load;
        s_load |=> st_q == ST_RUN
            && bright_q == $past(nvm_brightness)
            && fssel_q == ($past(nvm_fs_select) & `FSSEL_WMASK);
    endproperty
    a_nvm_load: assert property (p_nvm_load)
        else $error("nonvolatile image not loaded after reset");

    property p_spare_zero;
        addr_phase && !hwrite && reg_sel(haddr, `SPARE_IDX) |=>
            hrdata == `WORD_ZERO;
    endproperty
    a_spare_zero: assert property (p_spare_zero)
        else $error("spare register read nonzero");

    property p_group_a;
        failsafe_active |=>
            fm.out_a == pick($past(fm.sel_a), $past(fs_level));
    endproperty
    a_group_a: assert property (p_group_a)
        else $error("group A output ignores its fail-safe select");

    property p_group_b;
        failsafe_active ##1 failsafe_active |=>
            fm.out_b == pick($past(fm.sel_b), $past(fs_level));
    endproperty
    a_group_b: assert property (p_group_b)
        else $error("group B output ignores its fail-safe select");

    property p_fs_reserved;
        (s_fs_write |=> fssel_q == ($past(hwdata[7:0]) & `FSSEL_WMASK))
        and (fssel_q[`FS_RSV_HI] == 1'b0 && fssel_q[`FS_RSV_LO] == 1'b0);
    endproperty
    a_fs_reserved: assert property (p_fs_reserved)
        else $error("fail-safe select reserved bits not zero");

    property p_save_write;
        s_bright_write |=> power_save_enable == $past(hwdata[`SAVE_BIT]);
    endproperty
    a_save_write: assert property (p_save_write)
        else $error("power save enable wrong after write");

    // Outside fail-safe the channels carry the normal drive
    property p_normal_drive;
        rst_n && !failsafe_active |=>
            fm.out_a == $past(normal_a) && fm.out_b == $past(normal_b);
    endproperty
    a_normal_drive: assert property (p_normal_drive)
        else $error("channel outputs ignore the normal drive");

    property p_spare_write;
        addr_phase && hwrite && reg_sel(haddr, `SPARE_IDX) |->
            ##2 $stable(bright_q) && $stable(fssel_q);
    endproperty
    a_spare_write: assert property (p_spare_write)
        else $error("write to spare register changed a register");

    property p_fs_read;
        addr_phase && !hwrite && reg_sel(haddr, `FSSEL0_IDX) |=>
            hrdata[`FS_RSV_HI] == 1'b0 && hrdata[`FS_RSV_LO] == 1'b0;
    endproperty
    a_fs_read: assert property (p_fs_read)
        else $error("fail-safe select read shows reserved bits");

endmodule

// File: led_regs_cfg.svh
`ifndef LED_REGS_CFG_SVH
`define LED_REGS_CFG_SVH

// ----------------------------------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------------------------------
`define BRC_IDX 8'h7E
`define SPARE_IDX 8'h7F
`define FSSEL0_IDX 8'h80

// ----------------------------------------------------------------
// Reset and fixed values
// ----------------------------------------------------------------
`define REG_RST 8'h00
`define SPARE_VALUE 8'h00
`define FSSEL_WMASK 8'h77
`define RATE_RST 15'h00C8
`define WORD_ZERO 32'h0000_0000
`define UPPER_ZERO 22'h00_0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EXP_BIT 7
`define PHASE_BIT 6
`define FINE_BIT 5
`define SAVE_BIT 4
`define RATE_MSB 3
`define RATE_LSB 0
`define A_SEL_MSB 2
`define A_SEL_LSB 0
`define B_SEL_MSB 6
`define B_SEL_LSB 4
`define FS_RSV_HI 7
`define FS_RSV_LO 3
`define IDX_MSB 9
`define IDX_LSB 2
`define UPPER_LSB 10
`define TRANS_ACTIVE_BIT 1

`endif

// File: led_cfg_pkg.sv
`include "led_regs_cfg.svh"

package led_cfg_pkg;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b01,
        ST_RUN = 2'b10
    } load_state_t;

    // True when a byte address hits one register word
    function automatic logic reg_sel(input logic [31:0] a,
                                     input logic [7:0] idx);
        return (a[31:`UPPER_LSB] == `UPPER_ZERO) &&
               (a[`IDX_MSB:`IDX_LSB] == idx);
    endfunction

    // Per output: select bit 0 takes input zero, 1 takes input one
    function automatic logic [2:0] pick(input logic [2:0] sel,
                                        input logic [1:0] lvl);
        logic [2:0] o;
        o = 3'h0;
        for (int i = 0; i < 3; i++) begin
            o[i] = sel[i] ? lvl[1] : lvl[0];
        end
        return o;
    endfunction

    function automatic logic [14:0] rate_hz(input logic [3:0] code);
        logic [14:0] hz;
        hz = 15'h0000;
        unique case (code)
            4'h0: hz = 15'h00C8;
            4'h1: hz = 15'h00FA;
            4'h2: hz = 15'h012C;
            4'h3: hz = 15'h015E;
            4'h4: hz = 15'h0190;
            4'h5: hz = 15'h01F4;
            4'h6: hz = 15'h0258;
            4'h7: hz = 15'h0320;
            4'h8: hz = 15'h03E8;
            4'h9: hz = 15'h04B0;
            4'hA: hz = 15'h07D0;
            4'hB: hz = 15'h0FA0;
            4'hC: hz = 15'h170C;
            4'hD: hz = 15'h1E78;
            4'hE: hz = 15'h2580;
            4'hF: hz = 15'h5140;
        endcase
        return hz;
    endfunction

endpackage

// File: fs_map_if.sv
`timescale 1ns/100ps

interface fs_map_if;
    logic [2:0] sel_a;
    logic [2:0] sel_b;
    logic [1:0] level;
    logic active;
    logic [2:0] normal_a;
    logic [2:0] normal_b;
    logic [2:0] out_a;
    logic [2:0] out_b;

    modport regs (
        output sel_a, sel_b, level, active, normal_a, normal_b,
        input out_a, out_b
    );
    modport mux (
        input sel_a, sel_b, level, active, normal_a, normal_b,
        output out_a, out_b
    );
endinterface

// File: fs_pin_sync.sv
`timescale 1ns/100ps

module fs_pin_sync (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [1:0] pin,
    output logic [1:0] level
);
    logic [1:0] s1_q, s2_q, s3_q, lvl_q;
    logic [1:0] lvl_d;

    // A change counts only once the second and third stages agree
    always_comb begin
        lvl_d = lvl_q;
        for (int i = 0; i < 2; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                lvl_d[i] = s2_q[i];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s1_q <= 2'h0;
            s2_q <= 2'h0;
            s3_q <= 2'h0;
            lvl_q <= 2'h0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level = lvl_q;
endmodule

// File: fs_output_mux.sv
`timescale 1ns/100ps

module fs_output_mux
    import led_cfg_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    fs_map_if.mux fm
);
    logic [2:0] a_d, b_d, a_q, b_q;

    always_comb begin
        a_d = fm.normal_a;
        b_d = fm.normal_b;
        if (fm.active) begin
            a_d = pick(fm.sel_a, fm.level);
            b_d = pick(fm.sel_b, fm.level);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            a_q <= 3'h0;
            b_q <= 3'h0;
        end else begin
            a_q <= a_d;
            b_q <= b_d;
        end
    end

    assign fm.out_a = a_q;
    assign fm.out_b = b_q;
endmodule

// File: test_dimming_and_failsafe_map_regs.sv
`timescale 1ns/100ps

module test_dimming_and_failsafe_map_regs;

    // ------------------------------------------------------------
    // Signals and constants
    // ------------------------------------------------------------
    localparam logic [31:0] addr_brc = 32'h0000_01F8;
    localparam logic [31:0] addr_spare = 32'h0000_01FC;
    localparam logic [31:0] addr_fs = 32'h0000_0200;
    // Next word past the map, and an alias with a high address bit
    localparam logic [31:0] addr_none = 32'h0000_0204;
    localparam logic [31:0] addr_alias = 32'h0000_05F8;
    localparam int wait_max = 50;

    logic core_clk, rst_n, hsel, hwrite, hready;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp;
    logic [7:0] nvm_brightness, nvm_fs_select;
    logic failsafe_active, failsafe_input_zero, failsafe_input_one;
    logic [2:0] normal_a, normal_b;
    logic exponential_curve_enable, phase_shift_enable;
    logic fine_resolution_enable, power_save_enable;
    logic [3:0] pulse_rate_select;
    logic [14:0] pulse_rate_hz;
    logic group_a_output_0, group_a_output_1, group_a_output_2;
    logic group_b_output_0, group_b_output_1, group_b_output_2;
    logic [2:0] out_a, out_b;
    logic [7:0] val;
    logic [14:0] hz_table [16];
    int fail_count;
    int checks_done;

    assign hready = hreadyout;
    assign out_a = {group_a_output_2, group_a_output_1, group_a_output_0};
    assign out_b = {group_b_output_2, group_b_output_1, group_b_output_0};

    brightness_failsafe_regs dut (
        .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .nvm_brightness(nvm_brightness), .nvm_fs_select(nvm_fs_select),
        .failsafe_active(failsafe_active),
        .failsafe_input_zero(failsafe_input_zero),
        .failsafe_input_one(failsafe_input_one),
        .normal_a(normal_a), .normal_b(normal_b),
        .exponential_curve_enable(exponential_curve_enable),
        .phase_shift_enable(phase_shift_enable),
        .fine_resolution_enable(fine_resolution_enable),
        .power_save_enable(power_save_enable),
        .pulse_rate_select(pulse_rate_select),
        .pulse_rate_hz(pulse_rate_hz),
        .group_a_output_0(group_a_output_0),
        .group_a_output_1(group_a_output_1),
        .group_a_output_2(group_a_output_2),
        .group_b_output_0(group_b_output_0),
        .group_b_output_1(group_b_output_1),
        .group_b_output_2(group_b_output_2)
    );

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Bounded wait for an edge that samples hready high
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge core_clk);
        while (hready !== 1'b1 && n < wait_max) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= wait_max) begin
            fail_count++;
            $display("CHECK FAILED hready expected 1 seen stuck");
            results();
        end
    endtask

    // One single word transfer; read data is taken at the final edge
    task automatic xfer(input logic is_wr, input logic [31:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= is_wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= is_wr ? d : ~d;
        wait_ready();
        r = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask

    task automatic rd_check(input string name, input logic [31:0] a,
                            input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0000_0000, r);
        check(name, r, exp);
    endtask

    task automatic do_reset();
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        hz_table = '{15'h00C8, 15'h00FA, 15'h012C, 15'h015E, 15'h0190,
                     15'h01F4, 15'h0258, 15'h0320, 15'h03E8, 15'h04B0,
                     15'h07D0, 15'h0FA0, 15'h170C, 15'h1E78, 15'h2580,
                     15'h5140};
        fail_count = 0;
        checks_done = 0;
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        nvm_brightness = 8'hA5;
        nvm_fs_select = 8'hFF;
        failsafe_active = 1'b0;
        failsafe_input_zero = 1'b0;
        failsafe_input_one = 1'b0;
        normal_a = 3'h6;
        normal_b = 3'h3;
        do_reset();

        // Image loaded at release; reserved select bits dropped
        rd_check("brc_nvm", addr_brc, 32'h0000_00A5);
        rd_check("fs_nvm", addr_fs, 32'h0000_0077);
        check("exp_nvm", exponential_curve_enable, 32'h1);
        check("rate_nvm", pulse_rate_hz, 32'h01F4);
        check("outs_normal", {out_b, out_a}, 32'h1E);

        // Spare word and holes read zero, writes leave no trace
        rd_check("spare", addr_spare, 32'h0000_0000);
        wr(addr_spare, 32'hFFFF_FFFF);
        rd_check("spare_wr", addr_spare, 32'h0000_0000);
        rd_check("hole", addr_none, 32'h0000_0000);
        rd_check("alias", addr_alias, 32'h0000_0000);
        check("hresp", hresp, 32'h0);

        // Every rate code; flag bits walk through all combinations
        for (int c = 0; c < 16; c++) begin
            val = {c[3:0], c[3:0]};
            wr(addr_brc, {24'hFFFFFF, val});
            rd_check("brc_rd", addr_brc, {24'h000000, val});
            check("exp", exponential_curve_enable, val[7]);
            check("phase", phase_shift_enable, val[6]);
            check("fine", fine_resolution_enable, val[5]);
            check("save", power_save_enable, val[4]);
            check("rate_sel", pulse_rate_select, val[3:0]);
            check("rate_hz", pulse_rate_hz, hz_table[c]);
        end

        // Reserved select bits stay zero
        wr(addr_fs, 32'h0000_00FF);
        rd_check("fs_ones", addr_fs, 32'h0000_0077);
        wr(addr_fs, 32'h0000_0088);
        rd_check("fs_rsv", addr_fs, 32'h0000_0000);
        wr(addr_fs, 32'h0000_0052);
        rd_check("fs_map", addr_fs, 32'h0000_0052);

        // Group A picks 010, group B bits 6..4 pick 101
        failsafe_active <= 1'b1;
        failsafe_input_one <= 1'b1;
        repeat (8) @(posedge core_clk);
        check("fs_a", out_a, 32'h2);
        check("fs_b", out_b, 32'h5);
        failsafe_input_zero <= 1'b1;
        failsafe_input_one <= 1'b0;
        repeat (8) @(posedge core_clk);
        check("fs_a_swap", out_a, 32'h5);
        check("fs_b_swap", out_b, 32'h2);
        failsafe_active <= 1'b0;
        repeat (3) @(posedge core_clk);
        check("run_a", out_a, 32'h6);
        check("run_b", out_b, 32'h3);

        // Second reset in mid-run reloads the new image
        nvm_brightness <= 8'h3C;
        nvm_fs_select <= 8'h8B;
        do_reset();
        rd_check("brc_nvm2", addr_brc, 32'h0000_003C);
        rd_check("fs_nvm2", addr_fs, 32'h0000_0003);
        rd_check("spare2", addr_spare, 32'h0000_0000);
        check("rate_nvm2", pulse_rate_hz, 32'h170C);
        check("save_nvm2", power_save_enable, 32'h1);
        results();
    end

endmodule
